// File: hcpr_top.sv
`timescale 1ns/1ps
`include "hcpr_regs.svh"

module hcpr_top
	import hcpr_pkg::*;
#(
	parameter int ADDR_W = `HCPR_ADDR_W
) (
	input  wire logic              sys_clk,      // 250 MHz system clock
	input  wire logic              rstn,         // Synchronous reset, active low
	input  wire logic              clk_en,       // Freezes all state while low
	input  wire logic              cs_n_pin,     // Chip select pin, active low
	input  wire logic              rd_n_pin,     // Read strobe pin, active low
	input  wire logic              wr_n_pin,     // Write strobe pin, active low
	input  wire logic [ADDR_W-1:0] addr_pin,     // Byte address pins
	input  wire logic [31:0]       data_in,      // Data pins, inbound level
	output logic      [31:0]       data_out,     // Data pins, driven value
	output logic                   data_oe,      // High while driving data pins
	output logic                   op_space_sel, // Access falls in operational space
	output logic                   write_dropped // Pulse: write to this bank ignored
);

	localparam hcpr_state_t ST_RESET = '{
		sync1:      `HCPR_STROBE_IDLE,
		sync2:      `HCPR_STROBE_IDLE,
		sync3:      `HCPR_STROBE_IDLE,
		filt:       `HCPR_STROBE_IDLE,
		fsm:        HCPR_IDLE,
		addr:       16'h0000,
		rdata:      32'h0000_0000,
		data_oe:    1'b0,
		op_hit:     1'b0,
		write_drop: 1'b0
	};

	hcpr_struct_word_t struct_word;
	hcpr_cap_word_t    cap_word;
	hcpr_state_t       st;
	hcpr_state_t       next_st;
	logic [2:0]        agree;
	logic [15:0]       addr_w;

	hcpr_fields u_fields (
		.struct_word (struct_word),
		.cap_word    (cap_word)
	);

	assign addr_w = 16'(addr_pin);

	// Unmapped addresses read zero so a stray read never floats the bus
	function automatic logic [31:0] read_word(
		input logic [15:0]       a,
		input hcpr_struct_word_t sw,
		input hcpr_cap_word_t    cw
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (a == `HCPR_STRUCT_OFS) begin
			w = sw;
		end else if (a == `HCPR_CAP_OFS) begin
			w = cw;
		end
		return w;
	endfunction

	function automatic logic in_op_space(input logic [15:0] a);
		return a >= `HCPR_CAPLEN;
	endfunction

	always_comb begin
		next_st            = st;
		next_st.sync1      = {cs_n_pin, rd_n_pin, wr_n_pin};
		next_st.sync2      = st.sync1;
		next_st.sync3      = st.sync2;
		next_st.write_drop = 1'b0;
		// A strobe level counts only once stages two and three agree
		agree              = ~(st.sync2 ^ st.sync3);
		next_st.filt       = (agree & st.sync3) | (~agree & st.filt);
		case (st.fsm)
			HCPR_IDLE: begin
				// Address is assumed stable by the time the filtered strobe shows
				if (!st.filt[2] && !st.filt[1]) begin
					next_st.addr    = addr_w;
					next_st.rdata   = read_word(addr_w, struct_word, cap_word);
					next_st.data_oe = 1'b1;
					next_st.op_hit  = in_op_space(addr_w);
					next_st.fsm     = HCPR_READ;
				end else if (!st.filt[2] && !st.filt[0]) begin
					// Data is ignored: every field here is a fixed value
					next_st.addr       = addr_w;
					next_st.write_drop = !in_op_space(addr_w);
					next_st.op_hit     = in_op_space(addr_w);
					next_st.fsm        = HCPR_WRITE;
				end
			end
			HCPR_READ: begin
				if (st.filt[2] || st.filt[1]) begin
					next_st.data_oe = 1'b0;
					next_st.op_hit  = 1'b0;
					next_st.fsm     = HCPR_IDLE;
				end
			end
			HCPR_WRITE: begin
				if (st.filt[2] || st.filt[0]) begin
					next_st.op_hit = 1'b0;
					next_st.fsm    = HCPR_IDLE;
				end
			end
			default: begin
				next_st = ST_RESET;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st <= ST_RESET;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign data_out      = st.rdata;
	assign data_oe       = st.data_oe;
	assign op_space_sel  = st.op_hit;
	assign write_dropped = st.write_drop;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	logic unused_data;
	assign unused_data = ^data_in;

	sequence s_struct_read;
		data_oe && st.addr == `HCPR_STRUCT_OFS;
	endsequence

	sequence s_cap_read;
		data_oe && st.addr == `HCPR_CAP_OFS;
	endsequence

	a_struct_top_zero: assert property (s_struct_read |-> data_out[31:24] == 8'h00)
		else $error("structural reserved top byte not zero");
	a_debug_port_zero: assert property (s_struct_read |-> data_out[23:20] == 4'h0)
		else $error("debug port number not zero");
	a_indicator_clear: assert property (s_struct_read |-> !data_out[16])
		else $error("port indicator bit set");
	a_cc_count_zero: assert property (s_struct_read |-> data_out[15:12] == 4'h0)
		else $error("companion count not zero");
	a_per_cc_zero: assert property (s_struct_read |-> data_out[11:8] == 4'h0)
		else $error("ports per companion not zero");
	a_routing_clear: assert property (s_struct_read |-> !data_out[7])
		else $error("port routing bit set");
	a_power_ctrl_set: assert property (s_struct_read |-> data_out[4] && data_out[6:5] == 2'b00)
		else $error("port power control bit wrong");
	a_port_count_one: assert property (s_struct_read |-> data_out[3:0] == 4'h1)
		else $error("port count not one");
	a_cap_top_zero: assert property (s_cap_read |-> data_out[31:16] == 16'h0000)
		else $error("capability reserved half not zero");
	a_ext_ptr_zero: assert property (s_cap_read |-> data_out[15:8] == 8'h00)
		else $error("extended capability pointer not zero");
	a_iso_thresh_val: assert property (s_cap_read |-> data_out[7:4] == 4'h8)
		else $error("iso threshold not 1000b");
	a_async_park_set: assert property (s_cap_read |-> data_out[2] && !data_out[3])
		else $error("async park bit wrong");
	a_frame_list_set: assert property (s_cap_read |-> data_out[1] && !data_out[0])
		else $error("programmable frame list bit wrong");
	a_write_no_drive: assert property (write_dropped |-> !data_oe ##1 (!data_oe && $stable(data_out)))
		else $error("write to parameter word had an effect");
	a_op_space_sel: assert property ($rose(data_oe) |-> op_space_sel == (st.addr >= `HCPR_CAPLEN))
		else $error("operational space select wrong");
	a_read_release: assert property (clk_en && data_oe && st.filt[1] |=> !data_oe)
		else $error("data pins still driven after read release");

	// Handshake steps as the state machine sees them after the strobe filter
	sequence s_idle_read;
		clk_en && st.fsm == HCPR_IDLE && !st.filt[2] && !st.filt[1];
	endsequence

	sequence s_idle_write;
		clk_en && st.fsm == HCPR_IDLE && !st.filt[2] && st.filt[1] && !st.filt[0];
	endsequence

	a_read_grant: assert property (s_idle_read |=> data_oe && !write_dropped)
		else $error("filtered read strobe did not start a read");
	// Writes into operational space pass without a drop pulse
	a_write_flag: assert property (s_idle_write |=> !data_oe && write_dropped == (st.addr < `HCPR_CAPLEN))
		else $error("write drop flag wrong for address");
	a_drop_pulse: assert property (write_dropped && clk_en |=> !write_dropped)
		else $error("write drop flag held longer than one cycle");
	a_data_hold: assert property (clk_en && st.fsm != HCPR_IDLE |=> $stable(data_out))
		else $error("read data changed outside idle");
	a_idle_quiet: assert property (clk_en && st.fsm == HCPR_IDLE && st.filt[2] |=> !data_oe && !write_dropped)
		else $error("access started without chip select");

	// A low enable must hold every flop, synchroniser stages included
	a_freeze_hold: assert property (rstn && !clk_en |=> $stable(st))
		else $error("state moved while clock enable low");

	// Each strobe bit follows stage three only when stages two and three agree
	a_filter_agree: assert property (clk_en && st.sync2 == st.sync3 |=> st.filt == $past(st.sync3))
		else $error("filtered strobe ignored agreeing stages");
	a_filter_hold: assert property (clk_en && (st.sync2 ^ st.sync3) == 3'h7 |=> st.filt == $past(st.filt))
		else $error("filtered strobe moved on disagreeing stages");

endmodule // hcpr_top

// File: hcpr_regs.svh
`ifndef HCPR_REGS_SVH
`define HCPR_REGS_SVH

// Register map, byte addresses on the processor port
`define HCPR_ADDR_W          16
`define HCPR_STRUCT_OFS      16'h0004
`define HCPR_CAP_OFS         16'h0008
`define HCPR_CAPLEN          16'h0020

// Structural word field values
`define HCPR_DEBUG_PORT      4'h0
`define HCPR_PORT_IND        1'b0
`define HCPR_CC_COUNT        4'h0
`define HCPR_PORTS_PER_CC    4'h0
`define HCPR_ROUTING         1'b0
`define HCPR_POWER_CTRL      1'b1
`define HCPR_PORT_COUNT      4'h1

// Capability word field values
`define HCPR_EXT_CAP_PTR     8'h00
`define HCPR_ISO_THRESH      4'h8
`define HCPR_ASYNC_PARK      1'b1
`define HCPR_PROG_FRAME_LIST 1'b1

// Strobe pins idle high, reset value of each synchroniser stage
`define HCPR_STROBE_IDLE     3'h7

`endif

// File: hcpr_pkg.sv
package hcpr_pkg;

	typedef struct packed {
		logic [7:0] rsvd_hi;
		logic [3:0] debug_port_number;
		logic [2:0] rsvd_mid;
		logic       port_indicator;
		logic [3:0] companion_controller_count;
		logic [3:0] ports_per_companion;
		logic       port_routing_rules;
		logic [1:0] rsvd_lo;
		logic       port_power_control_support;
		logic [3:0] port_count;
	} hcpr_struct_word_t;

	typedef struct packed {
		logic [15:0] rsvd_hi;
		logic [7:0]  extended_capability_pointer;
		logic [3:0]  iso_schedule_threshold;
		logic        rsvd3;
		logic        async_park_capability;
		logic        programmable_frame_list_flag;
		logic        rsvd0;
	} hcpr_cap_word_t;

	typedef enum logic [2:0] {
		HCPR_IDLE  = 3'b001,
		HCPR_READ  = 3'b010,
		HCPR_WRITE = 3'b100
	} hcpr_fsm_t;

	// Strobe order in sync1, sync2, sync3 and filt: {cs, rd, wr}, all active low
	typedef struct packed {
		logic [2:0]  sync1;
		logic [2:0]  sync2;
		logic [2:0]  sync3;
		logic [2:0]  filt;
		hcpr_fsm_t   fsm;
		logic [15:0] addr;
		logic [31:0] rdata;
		logic        data_oe;
		logic        op_hit;
		logic        write_drop;
	} hcpr_state_t;

endpackage

// File: hcpr_fields.sv
`timescale 1ns/1ps
`include "hcpr_regs.svh"

module hcpr_fields
	import hcpr_pkg::*;
#(
	parameter logic [3:0] PORT_COUNT = `HCPR_PORT_COUNT,
	parameter logic [3:0] ISO_THRESH = `HCPR_ISO_THRESH
) (
	output hcpr_struct_word_t struct_word, // Structural parameter word
	output hcpr_cap_word_t    cap_word     // Capability parameter word
);

	always_comb begin
		struct_word                            = '0;
		struct_word.debug_port_number          = `HCPR_DEBUG_PORT;
		struct_word.port_indicator             = `HCPR_PORT_IND;
		struct_word.companion_controller_count = `HCPR_CC_COUNT;
		struct_word.ports_per_companion        = `HCPR_PORTS_PER_CC;
		struct_word.port_routing_rules         = `HCPR_ROUTING;
		struct_word.port_power_control_support = `HCPR_POWER_CTRL;
		struct_word.port_count                 = PORT_COUNT;
	end

	always_comb begin
		cap_word                              = '0;
		cap_word.extended_capability_pointer  = `HCPR_EXT_CAP_PTR;
		cap_word.iso_schedule_threshold       = ISO_THRESH;
		cap_word.async_park_capability        = `HCPR_ASYNC_PARK;
		cap_word.programmable_frame_list_flag = `HCPR_PROG_FRAME_LIST;
	end

endmodule // hcpr_fields

// File: hcpr_top_tb.sv
`timescale 1ns/1ps

module hcpr_top_tb;
	logic        sys_clk;
	logic        rstn;
	logic        clk_en;
	logic        cs_n_pin;
	logic        rd_n_pin;
	logic        wr_n_pin;
	logic [15:0] addr_pin;
	logic [31:0] data_in;
	logic [31:0] data_out;
	logic        data_oe;
	logic        op_space_sel;
	logic        write_dropped;
	int          n_errors;
	int          n_compared;
	int          cycles;
	integer      seed;

	hcpr_top #(.ADDR_W(16)) i_dut (
		.sys_clk       (sys_clk),
		.rstn          (rstn),
		.clk_en        (clk_en),
		.cs_n_pin      (cs_n_pin),
		.rd_n_pin      (rd_n_pin),
		.wr_n_pin      (wr_n_pin),
		.addr_pin      (addr_pin),
		.data_in       (data_in),
		.data_out      (data_out),
		.data_oe       (data_oe),
		.op_space_sel  (op_space_sel),
		.write_dropped (write_dropped)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic stop_test();
		if (n_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			n_errors++;
		end
	endtask

	// Fixed words; everything outside the two offsets reads zero
	function automatic logic [31:0] exp_word(input logic [15:0] a);
		if (a == 16'h0004) return {8'h00, 4'h0, 3'h0, 1'b0, 4'h0, 4'h0, 1'b0, 2'h0, 1'b1, 4'h1};
		if (a == 16'h0008) return {16'h0000, 8'h00, 4'h8, 1'b0, 1'b1, 1'b1, 1'b0};
		return 32'h00000000;
	endfunction

	task automatic bus_read(input logic [15:0] a);
		int k;
		@(posedge sys_clk);
		#1;
		addr_pin = a;
		cs_n_pin = 1'b0;
		rd_n_pin = 1'b0;
		k = 0;
		while (data_oe !== 1'b1 && k < 20) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		check("read_oe", {31'h0, data_oe}, 32'h1);
		check("read_data", data_out, exp_word(a));
		check("read_op_space", {31'h0, op_space_sel}, {31'h0, a >= 16'h0020});
		cs_n_pin = 1'b1;
		rd_n_pin = 1'b1;
		k = 0;
		while (data_oe !== 1'b0 && k < 20) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		check("release_oe", {31'h0, data_oe}, 32'h0);
		// Strobes must be seen idle for four cycles before the next access
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic bus_write(input logic [15:0] a, input logic [31:0] d);
		int drops;
		int oe_seen;
		int op_seen;
		@(posedge sys_clk);
		#1;
		addr_pin = a;
		data_in = d;
		cs_n_pin = 1'b0;
		wr_n_pin = 1'b0;
		drops = 0;
		oe_seen = 0;
		op_seen = 0;
		repeat (10) begin
			@(posedge sys_clk);
			#1;
			drops += int'(write_dropped === 1'b1);
			oe_seen += int'(data_oe === 1'b1);
			op_seen |= int'(op_space_sel === 1'b1);
		end
		check("write_drop_count", drops, (a < 16'h0020) ? 1 : 0);
		check("write_oe", oe_seen, 0);
		check("write_op_space", op_seen, (a >= 16'h0020) ? 1 : 0);
		cs_n_pin = 1'b1;
		wr_n_pin = 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	initial begin
		logic [15:0] a;
		seed = 32'hd414;
		n_errors = 0;
		n_compared = 0;
		cycles = 0;
		rstn = 1'b0;
		clk_en = 1'b1;
		cs_n_pin = 1'b1;
		rd_n_pin = 1'b1;
		wr_n_pin = 1'b1;
		addr_pin = 16'h0000;
		data_in = 32'h00000000;
		repeat (12) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		check("reset_oe", {31'h0, data_oe}, 32'h0);
		check("reset_data", data_out, 32'h00000000);
		bus_read(16'h0004);
		bus_read(16'h0008);
		bus_read(16'h001c);
		bus_read(16'h0020);
		bus_write(16'h0004, 32'hffffffff);
		bus_read(16'h0004);
		bus_write(16'h0008, 32'hffffffff);
		bus_read(16'h0008);
		bus_write(16'h001c, 32'h5a5a5a5a);
		// Command register write; a shorter frame list is allowed since the flag reads one
		bus_write(16'h0020, 32'ha5a5a5a5);
		// Strobes applied while the clock enable is low must not be seen
		@(posedge sys_clk);
		#1;
		clk_en = 1'b0;
		addr_pin = 16'h0008;
		cs_n_pin = 1'b0;
		rd_n_pin = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		check("freeze_oe", {31'h0, data_oe}, 32'h0);
		clk_en = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		check("thaw_oe", {31'h0, data_oe}, 32'h1);
		check("thaw_data", data_out, exp_word(16'h0008));
		cs_n_pin = 1'b1;
		rd_n_pin = 1'b1;
		repeat (8) @(posedge sys_clk);
		// Reset in mid-run must clear the held read data
		#1;
		rstn = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		check("midrun_oe", {31'h0, data_oe}, 32'h0);
		check("midrun_data", data_out, 32'h00000000);
		check("midrun_drop", {31'h0, write_dropped}, 32'h0);
		repeat (20) begin
			a = 16'($random(seed)) & (($random(seed) & 3) == 0 ? 16'hffff : 16'h003c);
			if ($random(seed) & 1) begin
				bus_write(a, $random(seed));
				bus_read(a);
			end else begin
				bus_read(a);
			end
		end
		stop_test();
	end
endmodule // hcpr_top_tb
